// File: logic/scrps_top.sv
// Module: clock distribution selects and reset pin sequencer
`timescale 1ns/1ps
`default_nettype none
module scrps_top
   import scrps_pkg::*;
#(
   // Sequence lengths in bus cycles
   parameter int unsigned LOW_CYC = PIN_LOW_BUS_CYC,
   parameter int unsigned SETTLE_CYC = PIN_SETTLE_BUS_CYC
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_bus_en,
   // Clock selection controls
   input wire logic [1:0] i_gen_src,
   input wire logic [15:0] i_gen_freq,
   input wire logic [15:0] i_ref_freq,
   input wire logic i_bus_slow,
   input wire logic i_dbg_self_req,
   input wire logic i_rti_ref_sel,
   input wire logic i_stop_self_en,
   input wire logic i_stop_recover,
   // Reset sources
   input wire logic i_por,
   input wire logic i_lvd,
   input wire logic i_wdog,
   input wire logic i_ilop,
   input wire logic i_ilad,
   // Reset pin
   input wire logic i_rst_pin,
   output logic o_rst_pin,
   output logic o_rst_pin_oe,
   // Outputs
   output logic o_fixed_freq_select,
   output logic [2:0] o_clock_gen_src_en,
   output logic o_bdc_self_clk_sel,
   output logic o_rti_ref_clk_sel,
   output logic o_adc_alt_is_ref,
   output logic o_self_clock_mode,
   output logic o_sys_rst,
   output logic [scrps_pkg::CAUSE_W-1:0] o_reset_cause
);
   import scrps_pkg::*;
   scrps_state_t state_q;
   logic [7:0] cnt_q;
   logic internal_q;
   logic [CAUSE_W-1:0] pend_q;
   logic [CAUSE_W-1:0] evt;
   logic int_evt;
   logic ext_evt;
   scrps_src_if src ();
   logic sys_rst_d;
   localparam logic [7:0] LOW_END = 8'(LOW_CYC - 1);
   localparam logic [7:0] SETTLE_END = 8'(SETTLE_CYC - 1);

   // ****************************************
   // Helpers
   // ****************************************
   // True on the bus pulse that completes a count
   function automatic logic count_end(input logic [7:0] cnt, input logic [7:0] last, input logic pulse);
      return pulse && (cnt == last);
   endfunction : count_end

   // One-hot cause word for a bit position
   function automatic logic [CAUSE_W-1:0] cause_bit(input int unsigned pos);
      return CAUSE_W'(1) << pos;
   endfunction : cause_bit

   // ****************************************
   // Clock selects
   // ****************************************
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_fixed_freq_select <= 1'b0;
      else
         o_fixed_freq_select <= {2'h0, i_gen_freq} > 18'(FFE_RATIO) * {2'h0, i_ref_freq}; // R1
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_bdc_self_clk_sel <= 1'b0;
         o_rti_ref_clk_sel <= 1'b0;
         o_adc_alt_is_ref <= 1'b0;
      end
      else
      begin
         o_bdc_self_clk_sel <= i_dbg_self_req & i_bus_slow; // R3
         o_rti_ref_clk_sel <= i_rti_ref_sel; // R4
         o_adc_alt_is_ref <= 1'b1; // R4
      end
   end

   // Self-clock held through the sequence, registered like every output
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_self_clock_mode <= 1'b1;
      else
         o_self_clock_mode <= sys_rst_d | (i_stop_recover & i_stop_self_en); // R5
   end

   assign src.gen_src = i_gen_src;
   assign src.self_mode = o_self_clock_mode; // R5
   assign o_clock_gen_src_en = src.gen_en;

   scrps_clk_mux u_mux (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .sel(src.mux)
   );

   // ****************************************
   // Reset sequencer
   // ****************************************
   // Internal sources placed at their cause positions
   always_comb
   begin
      evt = {CAUSE_W{1'b0}};
      if (i_por)
         evt = evt | cause_bit(CAUSE_POR);
      if (i_wdog)
         evt = evt | cause_bit(CAUSE_WDOG);
      if (i_ilop)
         evt = evt | cause_bit(CAUSE_ILOP);
      if (i_ilad)
         evt = evt | cause_bit(CAUSE_ILAD);
      if (i_lvd)
         evt = evt | cause_bit(CAUSE_LVD);
   end
   assign int_evt = |evt;
   assign ext_evt = ~i_rst_pin & ~o_rst_pin_oe & (state_q == SCR_IDLE); // R9
   // Sequence running, or about to start
   assign sys_rst_d = (state_q != SCR_IDLE && state_q != SCR_DONE) || int_evt || ext_evt;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         state_q <= SCR_DRIVE;
         cnt_q <= 8'h00;
         internal_q <= 1'b1;
      end
      else if (int_evt && state_q != SCR_DRIVE)
      begin
         state_q <= SCR_DRIVE; // R6
         cnt_q <= 8'h00;
         internal_q <= 1'b1;
      end
      else
         case (state_q)
            SCR_IDLE:
               if (ext_evt)
               begin
                  state_q <= SCR_DRIVE; // R6
                  cnt_q <= 8'h00;
                  internal_q <= 1'b0;
               end
            SCR_DRIVE:
               if (i_bus_en)
               begin
                  if (count_end(cnt_q, LOW_END, i_bus_en))
                  begin
                     state_q <= SCR_SETTLE; // R6
                     cnt_q <= 8'h00;
                  end
                  else
                     cnt_q <= cnt_q + 8'h01;
               end
            SCR_SETTLE:
               if (i_bus_en)
               begin
                  if (count_end(cnt_q, SETTLE_END, i_bus_en))
                     state_q <= i_rst_pin ? SCR_DONE : SCR_HELD; // R7 R10
                  else
                     cnt_q <= cnt_q + 8'h01;
               end
            SCR_HELD:
               if (i_rst_pin)
                  state_q <= SCR_DONE; // R10
            SCR_DONE:
               state_q <= SCR_IDLE;
            default:
               state_q <= SCR_IDLE;
         endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_rst_pin <= 1'b0;
         o_rst_pin_oe <= 1'b1;
         o_sys_rst <= 1'b1;
      end
      else
      begin
         o_rst_pin <= 1'b0;
         o_rst_pin_oe <= (state_q == SCR_DRIVE) && !count_end(cnt_q, LOW_END, i_bus_en); // R6
         o_sys_rst <= sys_rst_d;
      end
   end

   // Causes collected during the sequence, published at its end
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         pend_q <= CAUSE_RESET;
         o_reset_cause <= CAUSE_RESET;
      end
      else
      begin
         if (state_q == SCR_DONE)
         begin
            o_reset_cause <= pend_q | evt; // R8
            pend_q <= evt;
         end
         else if (ext_evt)
            pend_q <= pend_q | evt | cause_bit(CAUSE_PIN); // R8
         else
            pend_q <= pend_q | evt; // R8
         if (state_q == SCR_DONE && !internal_q)
            o_reset_cause[CAUSE_PIN] <= 1'b1;
      end
   end
endmodule : scrps_top
`default_nettype wire

// File: logic/scrps_pkg.sv
// Package: constants and types for the clock and reset-pin sequencer
// What this block does
// R1 - Select fixed clock as reference/2 when generator output exceeds four times reference
// R2 - Clock generator output comes from exactly one of three sources
// R3 - Offer roughly 8 MHz self-clock to the debug controller when bus clock slow
// R4 - Reference clock selectable for real-time interrupt and routed to converter
// R5 - Run from self-clock during reset startup; optional for stop recovery
// R6 - On any reset drive pin low 34 bus cycles, release, resample 38 later
// R7 - Internal reset expects the post-release pin sample to read high
// R8 - Decode each reset cause and set its bit in status register
// R9 - Outside party pulls pin low to reset; pin idles high by pullup
// R10 - Low sample after internal reset means held externally; stay in reset until high
package scrps_pkg;
   // ****************************************
   // Timing counts in bus cycles, and the fixed-clock frequency ratio
   // ****************************************
   localparam int unsigned PIN_LOW_BUS_CYC = 34;
   localparam int unsigned PIN_SETTLE_BUS_CYC = 38;
   localparam logic [7:0] PIN_LOW_CNT = 8'(PIN_LOW_BUS_CYC - 1);
   localparam logic [7:0] PIN_SETTLE_CNT = 8'(PIN_SETTLE_BUS_CYC - 1);
   localparam int unsigned FFE_RATIO = 4;
   // ****************************************
   // Clock source and reset cause encodings
   // ****************************************
   localparam logic [1:0] SRC_CRYSTAL = 2'h0;
   localparam logic [1:0] SRC_EXT_CLK = 2'h1;
   localparam logic [1:0] SRC_CTRL_OSC = 2'h2;
   localparam int unsigned CAUSE_W = 8;
   localparam int unsigned CAUSE_POR = 7;
   localparam int unsigned CAUSE_PIN = 6;
   localparam int unsigned CAUSE_WDOG = 5;
   localparam int unsigned CAUSE_ILOP = 4;
   localparam int unsigned CAUSE_ILAD = 3;
   localparam int unsigned CAUSE_LVD = 1;
   localparam logic [7:0] CAUSE_RESET = 8'h80;
   typedef enum logic [2:0] {SCR_IDLE, SCR_DRIVE, SCR_SETTLE, SCR_HELD, SCR_DONE} scrps_state_t;
endpackage : scrps_pkg

// File: logic/scrps_src_if.sv
// Interface: clock source selections passed to the clock mux
`timescale 1ns/1ps
`default_nettype none
interface scrps_src_if;
   logic [1:0] gen_src;
   logic self_mode;
   logic [2:0] gen_en;
   modport ctrl (output gen_src, output self_mode, input gen_en);
   modport mux (input gen_src, input self_mode, output gen_en);
endinterface : scrps_src_if
`default_nettype wire

// File: logic/scrps_clk_mux.sv
// Module: one-hot clock source selection for the generator output
`timescale 1ns/1ps
`default_nettype none
module scrps_clk_mux
   import scrps_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Selection
   scrps_src_if.mux sel
);
   import scrps_pkg::*;
   // Self-clock forces the controlled oscillator path during startup
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         sel.gen_en <= 3'h4;
      else if (sel.self_mode)
         sel.gen_en <= 3'h4; // R5
      else
         case (sel.gen_src) // R2
            SRC_CRYSTAL: sel.gen_en <= 3'h1;
            SRC_EXT_CLK: sel.gen_en <= 3'h2;
            default: sel.gen_en <= 3'h4;
         endcase
   end
endmodule : scrps_clk_mux
`default_nettype wire

// File: dv/scrps_asserts.sv
// Checker for the clock select and reset pin sequencer
`timescale 1ns/1ps
`default_nettype none
module scrps_asserts (
   // Inputs
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_bus_en,
   input wire logic [15:0] i_gen_freq,
   input wire logic [15:0] i_ref_freq,
   input wire logic i_bus_slow,
   input wire logic i_dbg_self_req,
   input wire logic i_rti_ref_sel,
   input wire logic i_wdog,
   // Outputs
   input wire logic o_rst_pin,
   input wire logic o_rst_pin_oe,
   input wire logic o_fixed_freq_select,
   input wire logic [2:0] o_clock_gen_src_en,
   input wire logic o_bdc_self_clk_sel,
   input wire logic o_rti_ref_clk_sel,
   input wire logic o_adc_alt_is_ref,
   input wire logic o_self_clock_mode,
   input wire logic o_sys_rst
);
   logic [7:0] cnt_q;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // Bus pulses seen while the pin is driven
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || !o_rst_pin_oe)
         cnt_q <= 8'h00;
      else if (i_bus_en)
         cnt_q <= cnt_q + 8'h01;
   end
   a_ffe_ratio: assert property (!$past(i_rst) |-> o_fixed_freq_select == ($past(i_gen_freq) > 18'($past(i_ref_freq)) * 4))
      else $error("fixed select");
   a_src_hot: assert property ($onehot(o_clock_gen_src_en))
      else $error("source enable");
   a_bdc_sel: assert property (!$past(i_rst) |-> o_bdc_self_clk_sel == $past(i_bus_slow && i_dbg_self_req))
      else $error("debug clock");
   a_rti_route: assert property (!$past(i_rst) |-> o_rti_ref_clk_sel == $past(i_rti_ref_sel) && o_adc_alt_is_ref)
      else $error("ref routing");
   a_self_boot: assert property (o_sys_rst |-> o_self_clock_mode)
      else $error("self clock");
   a_self_src: assert property ($past(o_sys_rst) |-> o_clock_gen_src_en == 3'h4)
      else $error("self source");
   a_pin_low: assert property (o_rst_pin_oe |-> !o_rst_pin)
      else $error("pin level");
   a_drive_len: assert property ($fell(o_rst_pin_oe) |-> cnt_q inside {[33:35]})
      else $error("drive length");
   a_wdog_start: assert property ($rose(i_wdog) && !o_sys_rst |-> ##[1:2] o_rst_pin_oe)
      else $error("drive start");
   c_done: cover property ($fell(o_sys_rst));
   c_drive: cover property ($fell(o_rst_pin_oe));
   c_ffe: cover property ($rose(o_fixed_freq_select));
endmodule : scrps_asserts
bind scrps_top scrps_asserts u_chk (.*);
`default_nettype wire

// File: dv/scrps_pin_model.sv
// Reset pin far side: pullup and external switch
`timescale 1ns/1ps
`default_nettype none
module scrps_pin_model (
   // Pin parties
   input wire logic i_oe,
   input wire logic i_drv,
   input wire logic i_press,
   output logic o_level
);
   assign o_level = !((i_oe && !i_drv) || i_press);
endmodule : scrps_pin_model
`default_nettype wire

// File: dv/tb_system_clock_reset_pin_seq.sv
// Testbench for the clock select and reset pin sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_reset_pin_seq;
   logic i_clk_sys = 0, i_rst = 1, i_bus_en = 0, i_bus_slow = 0, i_dbg_self_req = 0, i_rti_ref_sel = 0;
   logic i_stop_self_en = 0, i_stop_recover = 0, i_por = 0, i_lvd = 0, i_wdog = 0, i_ilop = 0, i_ilad = 0;
   logic press = 0;
   logic [1:0] i_gen_src = 2'h0;
   logic [15:0] i_gen_freq = 16'h0000, i_ref_freq = 16'h0064;
   wire logic i_rst_pin;
   logic o_rst_pin, o_rst_pin_oe, o_fixed_freq_select, o_bdc_self_clk_sel, o_rti_ref_clk_sel, o_adc_alt_is_ref;
   logic o_self_clock_mode, o_sys_rst;
   logic [2:0] o_clock_gen_src_en;
   logic [7:0] o_reset_cause;
   int errors = 0, n_checks = 0;
   scrps_top dut (.*);
   scrps_pin_model u_pin (.i_oe(o_rst_pin_oe), .i_drv(o_rst_pin), .i_press(press), .o_level(i_rst_pin));
   always #2 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) i_bus_en <= #1 ~i_bus_en;
   task automatic step();
      @(posedge i_clk_sys);
      #1;
   endtask : step
   task automatic wrap_up();
      if (errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_done();
      int i;
      i = 0;
      while (o_sys_rst !== 1'b0 && i < 900)
      begin
         step();
         i++;
      end
      if (i == 900)
      begin
         errors++;
         wrap_up();
      end
      else
         step();
   endtask : wait_done
   task automatic t_clk();
      for (int k = 0; k < 4; k++)
      begin
         {i_gen_src, i_bus_slow, i_dbg_self_req, i_rti_ref_sel} = {k[1:0], k[0], k[1], k[0]};
         {i_stop_self_en, i_stop_recover, i_gen_freq} = {k[1], k[0], 16'h0190 + k[15:0]};
         step();
         step();
         chk(o_fixed_freq_select, k > 0);
         chk(o_clock_gen_src_en, 3'h1 << (k > 2 ? 2 : k));
         chk(o_bdc_self_clk_sel, k == 3);
         chk({o_rti_ref_clk_sel, o_adc_alt_is_ref}, {k[0], 1'b1});
         chk(o_self_clock_mode, k == 3);
      end
      {i_stop_self_en, i_stop_recover} = 2'h0;
   endtask : t_clk
   task automatic t_cause(input logic [4:0] v);
      {i_por, i_wdog, i_ilop, i_ilad, i_lvd} = v;
      step();
      {i_por, i_wdog, i_ilop, i_ilad, i_lvd} = 5'h00;
      step();
      chk(o_sys_rst, 1);
      chk({o_rst_pin_oe, o_rst_pin}, 2'h2);
      wait_done();
      chk(o_reset_cause, {v[4], 1'b0, v[3:1], 1'b0, v[0], 1'b0});
   endtask : t_cause
   task automatic t_rerst();
      i_rst = 1;
      repeat (3) step();
      chk({o_sys_rst, o_rst_pin_oe}, 2'h3);
      i_rst = 0;
      wait_done();
      chk(o_reset_cause, 8'h80);
   endtask : t_rerst
   task automatic t_pin();
      press = 1;
      repeat (3) step();
      press = 0;
      wait_done();
      chk(o_reset_cause, 8'h40);
   endtask : t_pin
   task automatic t_held();
      i_lvd = 1;
      step();
      i_lvd = 0;
      press = 1;
      repeat (250) step();
      chk(o_sys_rst, 1);
      press = 0;
      wait_done();
      chk(o_reset_cause, 8'h02);
   endtask : t_held
   initial
   begin
      repeat (10) step();
      i_rst = 0;
      wait_done();
      chk(o_reset_cause, 8'h80);
      t_clk();
      for (int b = 0; b < 5; b++)
         t_cause(5'h01 << b);
      t_pin();
      t_held();
      t_rerst();
      wrap_up();
   end
endmodule : tb_system_clock_reset_pin_seq
`default_nettype wire
